// ### src/sqpo_regs.svh
// register offsets, field positions, reset values of the pulse re-output
// block; assumes a 32-bit apb slave decoding paddr[7:0]
`ifndef SQPO_REGS_SVH
`define SQPO_REGS_SVH

`define SQPO_CTRL_OFS      8'h00
`define SQPO_RES_OFS       8'h04
`define SQPO_PITCH_OFS     8'h08
`define SQPO_SPEED_OFS     8'h0c
`define SQPO_STAT_OFS      8'h10
`define SQPO_ISTAT_OFS     8'h14
`define SQPO_ICLR_OFS      8'h18
`define SQPO_IEN_OFS       8'h1c
`define SQPO_PMON_LO_OFS   8'h20
`define SQPO_PMON_HI_OFS   8'h24

`define SQPO_CTRL_DIRSEL   0
`define SQPO_CTRL_IDXOPT   1
`define SQPO_CTRL_CONV     2
`define SQPO_CTRL_CGATE    3
`define SQPO_CTRL_RESTART  4

`define SQPO_EV_SETERR     0
`define SQPO_EV_OVSPD      1
`define SQPO_EV_INDEX      2

`define SQPO_RES_RST       13'h0014
`define SQPO_RES_MAX       13'h1000
`define SQPO_PITCH_RST     24'h0007d0
`define SQPO_SPEED_RST     16'h0032
`define SQPO_PITCH_4UM     24'h000190
`define SQPO_SPEED_CAP     16'h000a
`define SQPO_LIM_MUL       40'h0000000048
`define SQPO_LIM_DIV       40'h0000000064
`define SQPO_IDX_STEPS     2'h2

`endif

// ### src/sqpo_pkg.sv
// types of the pulse re-output block; no assumptions on surroundings
package sqpo_pkg;
    // quadrature state, gray along the forward path 00-01-11-10
    typedef enum logic [1:0] {
        SQPO_Q_IDLE = 2'h0,
        SQPO_Q_A    = 2'h1,
        SQPO_Q_AB   = 2'h3,
        SQPO_Q_B    = 2'h2
    } sqpo_quad_t;
endpackage

// ### src/sqpo_top.sv
// quadrature pulse re-output of a linear scale, with index gating,
// resolution divider, setting and overspeed alarms, apb register file.
// assumes scale step, zero and speed inputs synchronous to CLK.
// Operation
// - phases A and B are offset by a quarter cycle, 90 degrees
// - each of A, B and C leaves as a true and inverted pair
// - index pulse lasts exactly one phase A high width
// - reverse direction select keeps the same A/B phase form
// - direction-dependent zero points give index pulses at two positions
// - optionally gate index on the scale count direction itself
// - first forward crossing emits index and arms later crossings of that zero point
// - reverse crossings suppressed until a forward crossing has emitted
// - arming is kept separately for every zero point
// - index option: 0 forward only, 1 both directions, after restart
// - with converter unit the index goes out in both directions
// - resolution 1 to 4096, default 20, applied at restart
// - divide four-times feedback edges per pitch down to resolution
// - resolution limited to pitch/100 over max speed times 72
// - pitch from setting with converter, else recognised pitch
// - at 4 um pitch the max speed is capped at 1 m/s
// - setting error alarm on range or limit violation
// - overspeed alarm when speed exceeds the resolution limit
`timescale 1ns/100ps
`include "sqpo_regs.svh"

module sqpo_top
    import sqpo_pkg::*;
#(
    parameter int ZW = 2                       // zero point id width
) (
    input  wire logic          CLK,            // system clock 100 MHz
    input  wire logic          SYS_RST,        // async reset, high
    input  wire logic          PSEL,           // apb select
    input  wire logic          PENABLE,        // apb access phase
    input  wire logic          PWRITE,         // apb direction
    input  wire logic [7:0]    PADDR,          // apb byte address
    input  wire logic [31:0]   PWDATA,         // apb write data
    output logic      [31:0]   PRDATA,         // apb read data
    output logic               PREADY,         // apb ready
    output logic               PSLVERR,        // apb error, unmapped
    input  wire logic          SCALE_STEP,     // one feedback edge
    input  wire logic          SCALE_UP,       // scale counts up
    input  wire logic          SCALE_ZERO,     // zero point passed
    input  wire logic [ZW-1:0] SCALE_ZERO_ID,  // which zero point
    input  wire logic [12:0]   SCALE_DIVS,     // divisions per pitch
    input  wire logic [23:0]   RECOG_PITCH,    // recognised pitch
    input  wire logic [15:0]   MOTOR_SPEED,    // speed, 0.1 m/s
    output logic               QUAD_OUT_A,     // phase A
    output logic               QUAD_OUT_A_N,   // phase A inverted
    output logic               QUAD_OUT_B,     // phase B
    output logic               QUAD_OUT_B_N,   // phase B inverted
    output logic               INDEX_OUT,      // phase C
    output logic               INDEX_OUT_N,    // phase C inverted
    output logic               IRQ             // level interrupt
);

    localparam int NZ = 1 << ZW;

    // next quadrature state; one function for both directions of travel, chosen by fwd
    function automatic sqpo_quad_t quad_next(input sqpo_quad_t q,
                                             input logic fwd);
        case (q)
            SQPO_Q_IDLE: quad_next = fwd ? SQPO_Q_A    : SQPO_Q_B;
            SQPO_Q_A:    quad_next = fwd ? SQPO_Q_AB   : SQPO_Q_IDLE;
            SQPO_Q_AB:   quad_next = fwd ? SQPO_Q_B    : SQPO_Q_A;
            SQPO_Q_B:    quad_next = fwd ? SQPO_Q_IDLE : SQPO_Q_AB;
            default:     quad_next = SQPO_Q_IDLE;
        endcase
    endfunction

    // software-side settings, as written
    logic [4:0]   ctrl_r;
    logic [12:0]  res_r;
    logic [23:0]  pitch_r;
    logic [15:0]  speed_r;
    logic [2:0]   ien_r;
    logic [2:0]   istat_r;
    // settings in force, copied only at restart
    logic [12:0]  res_act_r;
    logic [23:0]  pitch_act_r;
    logic [15:0]  speed_act_r;
    logic         dirsel_act_r;
    logic         idxopt_act_r;
    logic         conv_act_r;
    logic         cgate_act_r;
    logic         restart_r;
    // datapath state
    logic signed [15:0] acc_r;
    sqpo_quad_t   quad_r;
    logic [1:0]   idx_cnt_r;
    logic [NZ-1:0] armed_r;
    logic         seterr_r;
    logic         ovspd_r;

    // apb decode; the answer comes one cycle into the access phase
    wire acc_ph   = PSEL & PENABLE;
    wire xfer     = acc_ph & PREADY;
    wire wr_en    = xfer & PWRITE;
    wire sel_ctrl = PADDR == `SQPO_CTRL_OFS;
    wire sel_res  = PADDR == `SQPO_RES_OFS;
    wire sel_pit  = PADDR == `SQPO_PITCH_OFS;
    wire sel_spd  = PADDR == `SQPO_SPEED_OFS;
    wire sel_stat = PADDR == `SQPO_STAT_OFS;
    wire sel_ist  = PADDR == `SQPO_ISTAT_OFS;
    wire sel_iclr = PADDR == `SQPO_ICLR_OFS;
    wire sel_ien  = PADDR == `SQPO_IEN_OFS;
    wire sel_pml  = PADDR == `SQPO_PMON_LO_OFS;
    wire sel_pmh  = PADDR == `SQPO_PMON_HI_OFS;
    wire mapped   = sel_ctrl | sel_res | sel_pit | sel_spd | sel_stat |
                    sel_ist | sel_iclr | sel_ien | sel_pml | sel_pmh;
    wire restart_wr = wr_en & sel_ctrl & PWDATA[`SQPO_CTRL_RESTART];

    // read mux; status shows the resolution in force and live alarms
    wire [31:0] stat_word = {7'h00, idx_cnt_r, armed_r[0], quad_r,
                             res_act_r, 5'h00, ovspd_r, seterr_r};
    wire [31:0] rd_word =
        sel_ctrl ? {28'h0000000, ctrl_r[3:0]} :
        sel_res  ? {19'h00000, res_r} :
        sel_pit  ? {8'h00, pitch_r} :
        sel_spd  ? {16'h0000, speed_r} :
        sel_stat ? stat_word :
        sel_ist  ? {29'h00000000, istat_r} :
        sel_ien  ? {29'h00000000, ien_r} :
        sel_pml  ? {16'h0000, RECOG_PITCH[15:0]} :
        sel_pmh  ? {24'h000000, RECOG_PITCH[23:16]} : 32'h00000000;

    // apb handshake and read data
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= acc_ph & ~PREADY;
            PRDATA  <= (acc_ph & ~PREADY & ~PWRITE) ? rd_word : PRDATA;
            PSLVERR <= acc_ph & ~PREADY & ~mapped;
        end
    end

    // writable settings; restart bit is a self-clearing strobe
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_r  <= 5'h00;
            res_r   <= `SQPO_RES_RST;
            pitch_r <= `SQPO_PITCH_RST;
            speed_r <= `SQPO_SPEED_RST;
            ien_r   <= 3'h0;
        end else begin
            if (wr_en & sel_ctrl)
                ctrl_r <= {1'b0, PWDATA[3:0]};
            if (wr_en & sel_res)
                res_r <= PWDATA[12:0];
            if (wr_en & sel_pit)
                pitch_r <= PWDATA[23:0];
            if (wr_en & sel_spd)
                speed_r <= PWDATA[15:0];
            if (wr_en & sel_ien)
                ien_r <= PWDATA[2:0];
        end
    end

    // settings take effect only at restart, like a power cycle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            restart_r    <= 1'b0;
            res_act_r    <= `SQPO_RES_RST;
            pitch_act_r  <= `SQPO_PITCH_RST;
            speed_act_r  <= `SQPO_SPEED_RST;
            dirsel_act_r <= 1'b0;
            idxopt_act_r <= 1'b0;
            conv_act_r   <= 1'b0;
            cgate_act_r  <= 1'b0;
        end else begin
            restart_r <= restart_wr;
            if (restart_r) begin
                res_act_r    <= res_r;
                pitch_act_r  <= pitch_r;
                speed_act_r  <= speed_r;
                dirsel_act_r <= ctrl_r[`SQPO_CTRL_DIRSEL];
                idxopt_act_r <= ctrl_r[`SQPO_CTRL_IDXOPT];
                conv_act_r   <= ctrl_r[`SQPO_CTRL_CONV];
                cgate_act_r  <= ctrl_r[`SQPO_CTRL_CGATE];
            end
        end
    end

    // pitch source: setting with converter, else recognised pitch
    wire [23:0] pitch_eff = conv_act_r ? pitch_act_r : RECOG_PITCH;
    wire        pitch_4um = pitch_eff == `SQPO_PITCH_4UM;
    // 4 um pitch caps the maximum speed at the converter response limit
    wire [15:0] speed_eff = (pitch_4um && speed_act_r > `SQPO_SPEED_CAP) ?
                            `SQPO_SPEED_CAP : speed_act_r;
    // limit test without a divider: res*100*speed <= pitch*72
    wire [39:0] pitch_x72 = {16'h0000, pitch_eff} * `SQPO_LIM_MUL;
    wire [39:0] res_x100  = {27'h0000000, res_act_r} * `SQPO_LIM_DIV;
    wire [39:0] lim_lhs   = res_x100 * {24'h000000, speed_eff};
    wire [39:0] run_lhs   = res_x100 * {24'h000000, MOTOR_SPEED};
    wire res_range_bad = res_act_r == 13'h0000 ||
                         res_act_r > `SQPO_RES_MAX;
    wire res_lim_bad   = lim_lhs > pitch_x72;
    wire seterr_nxt    = res_range_bad | res_lim_bad;
    wire ovspd_nxt     = (run_lhs > pitch_x72) |
                         (pitch_4um & (MOTOR_SPEED > `SQPO_SPEED_CAP));

    // alarms; a bad setting freezes the pulse outputs
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            seterr_r <= 1'b0;
            ovspd_r  <= 1'b0;
        end else begin
            seterr_r <= seterr_nxt;
            ovspd_r  <= ovspd_nxt;
        end
    end

    // travel direction; reverse select flips the meaning of scale counts
    // so the output phase form stays that of standard travel
    wire        fwd       = SCALE_UP ^ dirsel_act_r;
    wire [15:0] edges_pp  = {1'b0, SCALE_DIVS, 2'b00};
    wire signed [15:0] res_s = $signed({3'b000, res_act_r});
    wire signed [15:0] n_s   = $signed(edges_pp);
    wire signed [15:0] acc_up = acc_r + res_s;
    wire signed [15:0] acc_dn = acc_r - res_s;
    wire run      = SCALE_STEP & ~seterr_r;
    wire wrap_up  = acc_up >= n_s;
    wire wrap_dn  = acc_dn < 16'sh0000;
    wire out_step = run & (fwd ? wrap_up : wrap_dn);
    wire signed [15:0] acc_nxt =
        ~run ? acc_r :
        fwd  ? (wrap_up ? acc_up - n_s : acc_up) :
               (wrap_dn ? acc_dn + n_s : acc_dn);
    wire sqpo_quad_t quad_nxt = out_step ? quad_next(quad_r, fwd) : quad_r;

    // resolution divider and quadrature sequencer
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc_r  <= 16'sh0000;
            quad_r <= SQPO_Q_IDLE;
        end else begin
            acc_r  <= restart_r ? 16'sh0000 : acc_nxt;
            quad_r <= quad_nxt;
        end
    end

    // index gating: count direction or travel direction, per zero point
    wire zdir_fwd  = cgate_act_r ? SCALE_UP : fwd;
    wire both_dirs = idxopt_act_r | conv_act_r;
    wire z_armed   = armed_r[SCALE_ZERO_ID];
    wire z_live    = SCALE_ZERO & ~seterr_r;
    // forward always emits; reverse only when armed and both allowed
    wire idx_fire  = z_live & (zdir_fwd | (both_dirs & z_armed));
    wire idx_ev    = idx_fire | (idx_cnt_r != 2'h0 && out_step);

    // arming bits, one per zero point, cleared by restart
    genvar gz;
    generate
        for (gz = 0; gz < NZ; gz++) begin : g_arm
            always_ff @(posedge CLK or posedge SYS_RST) begin
                if (SYS_RST)
                    armed_r[gz] <= 1'b0;
                else if (restart_r)
                    armed_r[gz] <= 1'b0;
                else if (z_live & zdir_fwd &&
                         SCALE_ZERO_ID == ZW'(gz))
                    armed_r[gz] <= 1'b1;
            end
        end
    endgenerate

    // index width counted in quadrature steps, one phase A high time,
    // so it scales with the resolution in force
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST)
            idx_cnt_r <= 2'h0;
        else if (idx_fire)
            idx_cnt_r <= `SQPO_IDX_STEPS;
        else if (idx_ev)
            idx_cnt_r <= idx_cnt_r - 2'h1;
    end

    // pin drivers: complementary pairs straight from flip-flops
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            QUAD_OUT_A   <= 1'b0;
            QUAD_OUT_A_N <= 1'b1;
            QUAD_OUT_B   <= 1'b0;
            QUAD_OUT_B_N <= 1'b1;
            INDEX_OUT    <= 1'b0;
            INDEX_OUT_N  <= 1'b1;
        end else begin
            QUAD_OUT_A   <= quad_nxt[0];
            QUAD_OUT_A_N <= ~quad_nxt[0];
            QUAD_OUT_B   <= quad_nxt[1];
            QUAD_OUT_B_N <= ~quad_nxt[1];
            INDEX_OUT    <= idx_fire | (idx_cnt_r != 2'h0 &&
                            !(idx_cnt_r == 2'h1 && out_step));
            INDEX_OUT_N  <= ~(idx_fire | (idx_cnt_r != 2'h0 &&
                            !(idx_cnt_r == 2'h1 && out_step)));
        end
    end

    // sticky events; a set in the same cycle as its clear wins
    wire [2:0] ev_set = {idx_fire, ovspd_nxt & ~ovspd_r,
                         seterr_nxt & ~seterr_r};
    wire [2:0] ev_clr = (wr_en & sel_iclr) ? PWDATA[2:0] : 3'h0;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            istat_r <= 3'h0;
            IRQ     <= 1'b0;
        end else begin
            istat_r <= (istat_r & ~ev_clr) | ev_set;
            IRQ     <= |(((istat_r & ~ev_clr) | ev_set) & ien_r);
        end
    end

    // checks on the logic above; one clock domain, masked in reset
    default clocking cb_chk @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_fwd_step;
        out_step && fwd && quad_r == SQPO_Q_IDLE;
    endsequence
    sequence s_a_rises;
        ##1 QUAD_OUT_A && !QUAD_OUT_B;
    endsequence

    a_quad_a_leads: assert property (s_fwd_step |-> s_a_rises)
        else $error("phase A does not lead on forward step");
    a_quad_gray: assert property (
        !(QUAD_OUT_A != $past(QUAD_OUT_A) &&
          QUAD_OUT_B != $past(QUAD_OUT_B)))
        else $error("phases A and B changed together");
    a_pair_compl: assert property (
        QUAD_OUT_A != QUAD_OUT_A_N && QUAD_OUT_B != QUAD_OUT_B_N &&
        INDEX_OUT != INDEX_OUT_N)
        else $error("output pair not complementary");
    a_rev_suppress: assert property (
        z_live && !zdir_fwd && !z_armed && idx_cnt_r == 2'h0 |=>
        !INDEX_OUT)
        else $error("index on reverse crossing before arming");
    a_fwd_arms: assert property (
        z_live && zdir_fwd && !restart_r |=> INDEX_OUT &&
        armed_r[$past(SCALE_ZERO_ID)])
        else $error("forward crossing did not emit and arm");
    a_fwd_only: assert property (
        z_live && !zdir_fwd && !both_dirs && idx_cnt_r == 2'h0 |=>
        !INDEX_OUT)
        else $error("reverse index while option is forward only");
    a_seterr_freeze: assert property (
        seterr_r |=> $stable(quad_r) && !$past(idx_fire))
        else $error("pulses moved under setting error");
    a_lim_alarm: assert property (
        (lim_lhs > pitch_x72) |=> seterr_r)
        else $error("limit violation without alarm");
    // a rising overspeed must also leave its sticky event bit
    a_ovspd_alarm: assert property (
        (run_lhs > pitch_x72) |=> ovspd_r &&
        (istat_r[1] || $past(ovspd_r)))
        else $error("overspeed not flagged");
    // while both steps are still owed the index cannot drop; a bounded
    // wait for motion would fire on a legally halted axis
    a_idx_width: assert property (
        INDEX_OUT && idx_cnt_r == 2'h2 |=> INDEX_OUT)
        else $error("index dropped before a quadrature step");
    // the index may only end on its second quadrature step
    a_idx_fall: assert property (
        $fell(INDEX_OUT) |-> $past(idx_cnt_r) == 2'h1 &&
        $past(out_step))
        else $error("index ended before its second step");
    a_irq_level: assert property (
        1'b1 |=> IRQ == (|(istat_r & $past(ien_r))))
        else $error("interrupt level not set by enabled status");
    a_apb_ready: assert property (
        PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("apb answer not after one wait");

endmodule // sqpo_top

// ### dv/sqpo_host_model.sv
// host-side quadrature counter: position, index pulses and form faults
// assumes phase outputs registered on the same clock as the model
`timescale 1ns/100ps
module sqpo_host_model (
    input  wire logic        clk,  // sample clock
    input  wire logic        rst,  // async reset, high
    input  wire logic        a,    // phase A
    input  wire logic        a_n,  // phase A inverted
    input  wire logic        b,    // phase B
    input  wire logic        b_n,  // phase B inverted
    input  wire logic        c,    // index
    input  wire logic        c_n,  // index inverted
    output logic      [15:0] pos,  // signed edge count
    output logic      [15:0] idx,  // index pulses seen
    output logic      [15:0] bad   // form faults seen
);
    logic [1:0] ab_r;
    logic       c_r;
    wire  [3:0] tr = {ab_r, a, b};
    // one quarter step per sample; a double change is a lost edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ab_r <= 2'h0;
            c_r  <= 1'b0;
            pos  <= 16'h0;
            idx  <= 16'h0;
            bad  <= 16'h0;
        end else begin
            ab_r <= {a, b};
            c_r  <= c;
            if (tr == 4'h2 || tr == 4'hb || tr == 4'hd || tr == 4'h4)
                pos <= pos + 16'h1;
            else if (tr == 4'h1 || tr == 4'h7 || tr == 4'he || tr == 4'h8)
                pos <= pos - 16'h1;
            if (tr == 4'h3 || tr == 4'hc || tr == 4'h6 || tr == 4'h9
                || a === a_n || b === b_n || c === c_n)
                bad <= bad + 16'h1;
            if (c && !c_r)
                idx <= idx + 16'h1;
        end
    end
endmodule // sqpo_host_model

// ### dv/scale_quadrature_pulse_output_test.sv
// bench of the pulse re-output block: apb master, scale stimulus, host
// model on the phase outputs; assumes one 100 MHz clock
`timescale 1ns/100ps
`include "sqpo_regs.svh"
module scale_quadrature_pulse_output_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, err;
    logic        step = 1'b0;
    logic        up = 1'b1;
    logic        zero = 1'b0;
    logic [1:0]  zid = 2'h0;
    logic [23:0] rpitch = 24'h0007d0;
    logic [15:0] speed = 16'h0032;
    logic        qa, qan, qb, qbn, qc, qcn;
    logic [15:0] pos, idx, bad, p0;
    int          fails = 0;
    int          cmp_count = 0;

    sqpo_top #(.ZW(2)) i_sqpo_top (.CLK(clk), .SYS_RST(rst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SCALE_STEP(step), .SCALE_UP(up), .SCALE_ZERO(zero),
        .SCALE_ZERO_ID(zid), .SCALE_DIVS(13'h000a), .RECOG_PITCH(rpitch),
        .MOTOR_SPEED(speed), .QUAD_OUT_A(qa), .QUAD_OUT_A_N(qan),
        .QUAD_OUT_B(qb), .QUAD_OUT_B_N(qbn), .INDEX_OUT(qc),
        .INDEX_OUT_N(qcn), .IRQ(irq));
    sqpo_host_model i_sqpo_host_model (.clk(clk), .rst(rst), .a(qa),
        .a_n(qan), .b(qb), .b_n(qbn), .c(qc), .c_n(qcn), .pos(pos),
        .idx(idx), .bad(bad));

    // clock and watchdog; 200 us is about fifty times the expected run
    initial forever #5 clk = ~clk;
    initial begin
        #200000;
        fails++;
        finish_test();
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // apb transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // no cycle count assumed: only the watchdog ends a hung wait
        while (pready !== 1'b1)
            @(posedge clk);
        rd   = prdata;
        err  = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic restart(input logic [3:0] c);
        apb(1'b1, `SQPO_CTRL_OFS, {27'h0, 1'b1, c});
        repeat (3) @(posedge clk);
    endtask
    // steps arrive back to back, one per cycle
    task automatic steps(input int n, input logic u);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            step <= 1'b1;
            up   <= u;
        end
        @(posedge clk);
        step <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic zc(input logic [1:0] id, input logic u, input logic f);
        @(posedge clk);
        zero <= 1'b1;
        zid  <= id;
        up   <= u;
        @(posedge clk);
        zero <= 1'b0;
        @(posedge clk);
        chk("index_out", {31'h0, f}, {31'h0, qc});
        if (f)
            steps(4, u);
    endtask
    task automatic osp(input logic [23:0] rp, input logic [15:0] sp,
                       input logic [3:0] c, input logic e);
        rpitch <= rp;
        speed  <= sp;
        restart(c);
        apb(1'b0, `SQPO_STAT_OFS, 32'h0);
        chk("overspeed", {31'h0, e}, {31'h0, rd[1]});
        chk("no_seterr", 32'h0, {31'h0, rd[0]});
    endtask

    task automatic t_reset();
        chk("phase_pair", 32'h1, {30'h0, qa, qan});
        apb(1'b0, `SQPO_RES_OFS, 32'h0);
        chk("res_reset", 32'h14, rd);
        apb(1'b0, `SQPO_STAT_OFS, 32'h0);
        chk("res_in_force", 32'h14, {19'h0, rd[19:7]});
        apb(1'b0, `SQPO_PMON_LO_OFS, 32'h0);
        chk("pitch_mon", 32'h7d0, rd);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask
    task automatic t_motion();
        restart(4'h0);
        p0 = pos;
        steps(40, 1'b1);
        chk("fwd_edges", 32'h14, {16'h0, pos - p0});
        steps(8, 1'b0);
        chk("rev_edges", 32'h10, {16'h0, pos - p0});
        restart(4'h1);
        steps(8, 1'b1);
        chk("dirsel_edges", 32'hc, {16'h0, pos - p0});
        chk("phase_form", 32'h0, {16'h0, bad});
        $display("test motion done");
    endtask
    task automatic t_index();
        p0 = idx;
        apb(1'b1, `SQPO_IEN_OFS, 32'h4);
        restart(4'h2);
        zc(2'h0, 1'b0, 1'b0);
        @(posedge clk);
        zero <= 1'b1;
        up   <= 1'b1;
        @(posedge clk);
        zero <= 1'b0;
        steps(2, 1'b1);
        chk("idx_width", 32'h1, {31'h0, qc});
        steps(2, 1'b1);
        chk("idx_end", 32'h1, {30'h0, qc, qcn});
        chk("irq_set", 32'h1, {31'h0, irq});
        apb(1'b1, `SQPO_ICLR_OFS, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        zc(2'h0, 1'b0, 1'b1);
        zc(2'h1, 1'b0, 1'b0);
        restart(4'h0);
        zc(2'h0, 1'b1, 1'b1);
        zc(2'h0, 1'b0, 1'b0);
        restart(4'h4);
        zc(2'h0, 1'b1, 1'b1);
        zc(2'h0, 1'b0, 1'b1);
        restart(4'h9);
        zc(2'h2, 1'b1, 1'b1);
        chk("idx_count", 32'h6, {16'h0, idx - p0});
        $display("test index done");
    endtask
    task automatic t_alarm();
        logic [31:0] resv [5];
        logic [4:0]  errv;
        resv = '{32'h1d, 32'h1c, 32'h0, 32'h1001, 32'h14};
        errv = 5'h0d;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `SQPO_RES_OFS, resv[i]);
            restart(4'h0);
            apb(1'b0, `SQPO_STAT_OFS, 32'h0);
            chk("seterr", {31'h0, errv[i]}, {31'h0, rd[0]});
            p0 = pos;
            steps(4, 1'b1);
            chk("err_steps", errv[i] ? 32'h0 : 32'h2,
                {16'h0, pos - p0});
        end
        // max speed setting of 10 m/s breaks the limit at resolution 20
        apb(1'b1, `SQPO_SPEED_OFS, 32'h64);
        restart(4'h0);
        apb(1'b0, `SQPO_STAT_OFS, 32'h0);
        chk("speed_lim", 32'h1, {31'h0, rd[0]});
        apb(1'b1, `SQPO_SPEED_OFS, 32'h32);
        osp(24'h0007d0, 16'h0048, 4'h0, 1'b0);
        osp(24'h0007d0, 16'h0049, 4'h0, 1'b1);
        osp(24'h000190, 16'h000b, 4'h0, 1'b1);
        osp(24'h000190, 16'h000a, 4'h0, 1'b0);
        osp(24'h000190, 16'h000b, 4'h4, 1'b0);
        $display("test alarm done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // reset for six cycles, then the scenarios in order
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_motion();
        t_index();
        t_alarm();
        finish_test();
    end
endmodule // scale_quadrature_pulse_output_test
